// File: src/fsc_pkg.sv
/*
 Constants and types of the synthesizer serial control block: frame layout,
 register addresses, field positions, reset values and decoded types.
 Assumes only a SystemVerilog compiler; no other package is needed.
*/
package fsc_pkg;
   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int FRAME_W = 24;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam int NREG = 128;
   localparam logic [4:0] BITS_ADDR = 5'h08;
   localparam logic [4:0] BITS_LAST = 5'h17;
   localparam logic [4:0] BITS_FULL = 5'h18;

   typedef struct packed {
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fsc_frame_t;

   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] A_CTRL = 7'h00;
   localparam logic [ADDR_W-1:0] A_NINT = 7'h26;
   localparam logic [ADDR_W-1:0] A_DEN_LO = 7'h28;
   localparam logic [ADDR_W-1:0] A_DEN_HI = 7'h29;
   localparam logic [ADDR_W-1:0] A_NUM_LO = 7'h2c;
   localparam logic [ADDR_W-1:0] A_NUM_HI = 7'h2d;
   localparam logic [ADDR_W-1:0] A_LOOP = 7'h50;
   localparam logic [ADDR_W-1:0] A_CHDIV = 7'h51;
   localparam logic [ADDR_W-1:0] A_OUT = 7'h52;
   localparam logic [ADDR_W-1:0] A_SEED_LO = 7'h53;
   localparam logic [ADDR_W-1:0] A_SEED_HI = 7'h54;

   // ----------------------------------------
   // Field positions and widths
   // ----------------------------------------
   localparam int B_SLEEP = 0;
   localparam int B_RESET = 1;
   localparam int B_MUXSEL = 2;
   localparam int B_CAL = 3;
   localparam int B_LDEN = 13;
   localparam int NINT_LSB = 1;
   localparam int NINT_W = 12;
   localparam int B_PRE4 = 0;
   localparam int B_OSC2X = 1;
   localparam int ORD_LSB = 2;
   localparam int ORD_W = 3;
   localparam int DLY_LSB = 5;
   localparam int DLY_W = 4;
   localparam int B_SEG1 = 0;
   localparam int SEG2_LSB = 1;
   localparam int SEG3_LSB = 4;
   localparam int SEG_W = 3;
   localparam int SMUX_LSB = 7;
   localparam int SMUX_W = 2;
   localparam int B_CHEN = 9;
   localparam int SON_LSB = 10;
   localparam int B_BUFA = 13;
   localparam int B_BUF = 14;
   localparam int B_OUTA = 0;
   localparam int B_OUTB = 1;
   localparam int LVA_LSB = 2;
   localparam int LVB_LSB = 8;
   localparam int LV_W = 6;

   // ----------------------------------------
   // Values and reset contents
   // ----------------------------------------
   localparam logic [2:0] PRE_LO = 3'h2;
   localparam logic [2:0] PRE_HI = 3'h4;
   localparam logic [ORD_W-1:0] ORD_INT = 3'h0;
   localparam logic [ORD_W-1:0] ORD_MAX = 3'h4;
   localparam logic [SMUX_W-1:0] SMUX_ONE = 2'h0;
   localparam logic [SMUX_W-1:0] SMUX_TWO = 2'h1;
   localparam logic [DATA_W-1:0] CTRL_DEF = 16'h0200;
   localparam logic [DATA_W-1:0] DEN_LO_DEF = 16'h0001;
   localparam int REGS_W = NREG * DATA_W;
   localparam logic [REGS_W-1:0] REGS_DEF = REGS_W'(CTRL_DEF)
      | (REGS_W'(DEN_LO_DEF) << (DATA_W * int'(A_DEN_LO)));

   typedef struct packed {
      logic master;
      logic [2:0] seg_on;
      logic buf_a_on;
      logic buf_on;
      logic [7:0] ratio;
   } fsc_chdiv_t;

   // Ratio of the second and third channel divider stage
   function automatic logic [7:0] seg_ratio(input logic [SEG_W-1:0] code);
      case (code)
         3'h0: return 8'h01;
         3'h1: return 8'h02;
         3'h2: return 8'h04;
         3'h3: return 8'h06;
         default: return 8'h08;
      endcase
   endfunction
endpackage

// File: src/fsc_link.sv
/*
 Serial clock side of the programming port: input shift register, bit count,
 read address capture and the readback driver.
 Assumes the serial clock toggles only while chip select is low and that the
 core takes the frame only after chip select has returned high.
*/
module fsc_link
   import fsc_pkg::*;
(
   // Link clock and reset
   input wire logic sclk_i,
   input wire logic rst_n_i,
   // Serial pins
   input wire logic chip_select_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   // Core side
   input wire logic [DATA_W-1:0] rd_word_i,
   output fsc_frame_t frame_o,
   output logic [4:0] bits_o,
   output logic [ADDR_W-1:0] rd_addr_o
);
   typedef struct packed {
      logic [FRAME_W-1:0] sh;
      logic [4:0] cnt;
      logic rd;
      logic [ADDR_W-1:0] addr;
   } fsc_lk_st_t;

   fsc_lk_st_t q, n;
   logic fresh;
   logic [4:0] idx;

   // ----------------------------------------
   // Frame start marker
   // ----------------------------------------
   // Set while deselected, so the first edge of a frame restarts the count
   always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   // ----------------------------------------
   // Shift register
   // ----------------------------------------
   always_comb begin
      n = q;
      if (!chip_select_n_i) begin
         n.sh = {q.sh[FRAME_W-2:0], sdi_i};
         if (fresh) begin
            n.cnt = 5'h01;
         end else if (q.cnt != BITS_FULL) begin
            n.cnt = q.cnt + 5'h01;
         end
         if (n.cnt == BITS_ADDR) begin
            n.rd = n.sh[ADDR_W];
            n.addr = n.sh[ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------
   // Readback driver
   // ----------------------------------------
   // Changes on the falling edge so the host samples on the rising one
   assign idx = BITS_LAST - q.cnt;

   always_ff @(negedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdo_o <= 1'b0;
      end else if (!chip_select_n_i && q.rd && q.cnt >= BITS_ADDR && q.cnt < BITS_FULL) begin
         sdo_o <= rd_word_i[idx[3:0]];
      end
   end

   assign frame_o = q.sh;
   assign bits_o = q.cnt;
   assign rd_addr_o = q.addr;
endmodule

// File: src/fsc_top.sv
/*
 Top of the synthesizer serial control block: serial register port, register
 bank, power-down, calibration trigger, lock or readback pin, prescaler,
 channel divider control and the fractional noise-shaping modulator.
 Assumes the host holds chip select high for at least four core clocks
 between frames and drives the serial clock only inside a frame.
*/
module fsc_top
   import fsc_pkg::*;
#(
   parameter int ACC_W = 32
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Serial port, clocked by the host
   input wire logic sclk_i,
   input wire logic chip_select_n_i,
   input wire logic sdi_i,
   // Device pins
   input wire logic chip_enable_i,
   input wire logic lock_i,
   output logic multipurpose_out_pin_o,
   // Events and power
   output logic power_down_o,
   output logic freq_cal_start_o,
   output logic seed_pulse_o,
   // Feedback divider
   output logic [NINT_W:0] n_div_o,
   output logic [ORD_W-1:0] mash_order_o,
   output logic [2:0] pre_ratio_o,
   output logic [DLY_W-1:0] detector_delay_select_o,
   output logic osc_doubler_enable_o,
   // Lock detect and pin select
   output logic lock_detect_enable_o,
   output logic multipurpose_out_select_o,
   // Channel divider and outputs
   output fsc_chdiv_t chdiv_o,
   output logic out_a_sel_o,
   output logic out_b_sel_o,
   output logic [LV_W-1:0] out_a_level_o,
   output logic [LV_W-1:0] out_b_level_o
);
   typedef struct packed {
      logic [1:0] csn_s;
      logic csn_d;
      logic [1:0] ce_s;
      logic [1:0] lk_s;
      logic [NREG-1:0][DATA_W-1:0] regs;
      logic pd;
      logic cal;
      logic seed;
      logic [3:0][ACC_W-1:0] acc;
      logic y4_d;
      logic signed [2:0] t3_d;
      logic signed [3:0] t2_d;
      logic [NINT_W:0] ndiv;
      logic [2:0] pre;
      fsc_chdiv_t chd;
   } fsc_st_t;

   fsc_st_t q, n;
   logic [1:0] rst_s;
   logic rst_n;
   fsc_frame_t fr;
   logic [4:0] bits;
   logic [ADDR_W-1:0] rd_addr;
   logic sdo;
   logic take;
   logic wr;
   logic [DATA_W-1:0] ctrl, loop, chd_cfg, out_cfg;
   logic [ACC_W-1:0] num, den, seed_val;
   logic [ORD_W-1:0] ord;
   logic [3:0] cy;
   logic [ACC_W:0] sum;
   logic signed [2:0] t3;
   logic signed [3:0] t2;
   logic signed [4:0] yv;
   logic [7:0] r1, r2, r3;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s <= 2'h0;
      end else begin
         rst_s <= {rst_s[0], 1'b1};
      end
   end
   assign rst_n = rst_s[1];

   // ----------------------------------------
   // Serial clock domain
   // ----------------------------------------
   fsc_link u_link (
      .sclk_i(sclk_i),
      .rst_n_i(rst_n),
      .chip_select_n_i(chip_select_n_i),
      .sdi_i(sdi_i),
      .sdo_o(sdo),
      .rd_word_i(q.regs[rd_addr]),
      .frame_o(fr),
      .bits_o(bits),
      .rd_addr_o(rd_addr)
   );

   // Residue add: result stays below the denominator, carry marks the wrap
   function automatic logic [ACC_W:0] mod_add(input logic [ACC_W-1:0] a,
      input logic [ACC_W-1:0] b, input logic [ACC_W-1:0] d);
      logic [ACC_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (d == '0) begin
         return '0;
      end else if (s >= {1'b0, d}) begin
         s = s - {1'b0, d};
         return {1'b1, s[ACC_W-1:0]};
      end
      return s;
   endfunction

   // ----------------------------------------
   // Register fields
   // ----------------------------------------
   assign ctrl = q.regs[A_CTRL];
   assign loop = q.regs[A_LOOP];
   assign chd_cfg = q.regs[A_CHDIV];
   assign out_cfg = q.regs[A_OUT];
   assign num = ACC_W'({q.regs[A_NUM_HI], q.regs[A_NUM_LO]});
   assign den = ACC_W'({q.regs[A_DEN_HI], q.regs[A_DEN_LO]});
   assign seed_val = ACC_W'({q.regs[A_SEED_HI], fr.data});
   // Frame stays still while chip select is high, so it is safe to take here
   assign take = q.csn_s[1] && !q.csn_d && bits == BITS_FULL;
   assign wr = take && !fr.rd;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n = q;
      cy = 4'h0;
      sum = '0;
      n.csn_s = {q.csn_s[0], chip_select_n_i};
      n.csn_d = q.csn_s[1];
      n.ce_s = {q.ce_s[0], chip_enable_i};
      n.lk_s = {q.lk_s[0], lock_i};
      n.cal = 1'b0;
      n.seed = 1'b0;
      n.pd = !q.ce_s[1] || ctrl[B_SLEEP];
      ord = loop[ORD_LSB +: ORD_W];
      if (ord > ORD_MAX) begin
         ord = ORD_MAX;
      end

      // Modulator stages, each after the first fed by the residue of the one before
      for (int k = 0; k < 4; k++) begin
         sum = mod_add(q.acc[k], (k == 0) ? num : sum[ACC_W-1:0], den);
         if (k < int'(ord)) begin
            cy[k] = sum[ACC_W];
            n.acc[k] = sum[ACC_W-1:0];
         end else begin
            n.acc[k] = '0;
         end
      end
      t3 = $signed({2'h0, cy[2]}) + $signed({2'h0, cy[3]}) - $signed({2'h0, q.y4_d});
      t2 = $signed({3'h0, cy[1]}) + 4'(t3) - 4'(q.t3_d);
      yv = $signed({4'h0, cy[0]}) + 5'(t2) - 5'(q.t2_d);
      n.y4_d = cy[3];
      n.t3_d = t3;
      n.t2_d = t2;
      n.ndiv = {1'h0, q.regs[A_NINT][NINT_LSB +: NINT_W]} + (NINT_W+1)'(yv);

      // Prescaler
      if (loop[B_OSC2X] || loop[B_PRE4]) begin
         n.pre = PRE_HI;
      end else begin
         n.pre = PRE_LO;
      end

      // Channel divider
      r1 = chd_cfg[B_SEG1] ? 8'h03 : 8'h02;
      r2 = seg_ratio(chd_cfg[SEG2_LSB +: SEG_W]);
      r3 = seg_ratio(chd_cfg[SEG3_LSB +: SEG_W]);
      n.chd.master = chd_cfg[B_CHEN];
      n.chd.seg_on = chd_cfg[B_CHEN] ? chd_cfg[SON_LSB +: 3] : 3'h0;
      n.chd.buf_a_on = chd_cfg[B_CHEN] && chd_cfg[B_BUFA];
      n.chd.buf_on = chd_cfg[B_CHEN] && chd_cfg[B_BUF];
      case (chd_cfg[SMUX_LSB +: SMUX_W])
         SMUX_ONE: n.chd.ratio = r1;
         SMUX_TWO: n.chd.ratio = 8'(r1 * r2);
         default: n.chd.ratio = 8'(r1 * r2 * r3);
      endcase
      if (!chd_cfg[B_CHEN]) begin
         n.chd.ratio = 8'h00;
      end

      // Register writes
      if (wr) begin
         if (fr.addr == A_CTRL && fr.data[B_RESET]) begin
            n.regs = REGS_DEF;
         end else begin
            n.regs[fr.addr] = fr.data;
         end
         if (fr.addr == A_CTRL && fr.data[B_CAL]) begin
            n.cal = 1'b1;
         end
         if (fr.addr == A_SEED_LO && ord != ORD_INT) begin
            n.seed = 1'b1;
            n.acc[0] = seed_val;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.csn_s <= 2'h3;
         q.csn_d <= 1'b1;
         q.regs <= REGS_DEF;
         q.pd <= 1'b1;
         q.pre <= PRE_LO;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_comb begin
      if (!ctrl[B_MUXSEL]) begin
         multipurpose_out_pin_o = sdo;
      end else begin
         multipurpose_out_pin_o = ctrl[B_LDEN] && q.lk_s[1];
      end
   end

   assign power_down_o = q.pd;
   assign freq_cal_start_o = q.cal;
   assign seed_pulse_o = q.seed;
   assign n_div_o = q.ndiv;
   assign mash_order_o = loop[ORD_LSB +: ORD_W];
   assign pre_ratio_o = q.pre;
   assign detector_delay_select_o = loop[DLY_LSB +: DLY_W];
   assign osc_doubler_enable_o = loop[B_OSC2X];
   assign lock_detect_enable_o = ctrl[B_LDEN];
   assign multipurpose_out_select_o = ctrl[B_MUXSEL];
   assign chdiv_o = q.chd;
   assign out_a_sel_o = out_cfg[B_OUTA];
   assign out_b_sel_o = out_cfg[B_OUTB];
   assign out_a_level_o = out_cfg[LVA_LSB +: LV_W];
   assign out_b_level_o = out_cfg[LVB_LSB +: LV_W];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   sequence s_wr(logic [ADDR_W-1:0] a);
      take && !fr.rd && fr.addr == a;
   endsequence

   property p_cal;
      s_wr(A_CTRL) ##0 fr.data[B_CAL] |=> freq_cal_start_o ##1 !freq_cal_start_o;
   endproperty
   a_cal: assert property (p_cal) else $error("calibration pulse missing");

   property p_cal_cause;
      freq_cal_start_o |-> $past(wr) && $past(fr.addr) == A_CTRL;
   endproperty
   a_cal_cause: assert property (p_cal_cause) else $error("stray calibration");

   property p_pre_set;
      pre_ratio_o == PRE_LO || pre_ratio_o == PRE_HI;
   endproperty
   a_pre_set: assert property (p_pre_set) else $error("bad prescaler ratio");

   property p_pre2x;
      osc_doubler_enable_o |=> pre_ratio_o == PRE_HI;
   endproperty
   a_pre2x: assert property (p_pre2x) else $error("doubler without prescale 4");

   property p_pre_wr;
      s_wr(A_LOOP) ##0 fr.data[B_OSC2X] |=> ##1 pre_ratio_o == PRE_HI;
   endproperty
   a_pre_wr: assert property (p_pre_wr) else $error("prescaler not forced");

   property p_ce;
      !chip_enable_i [*4] |-> power_down_o;
   endproperty
   a_ce: assert property (p_ce) else $error("no power down on chip enable");

   property p_sleep;
      s_wr(A_CTRL) ##0 fr.data[B_SLEEP] && !fr.data[B_RESET] |=> ##1 power_down_o;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no power down on sleep bit");

   property p_soft;
      s_wr(A_CTRL) ##0 fr.data[B_RESET] |=> out_a_level_o == '0 && !lock_detect_enable_o;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset left a register");

   property p_rbk;
      !multipurpose_out_select_o |-> multipurpose_out_pin_o == sdo;
   endproperty
   a_rbk: assert property (p_rbk) else $error("pin not on readback");

   property p_lock;
      (multipurpose_out_select_o && lock_detect_enable_o && lock_i) [*3] |-> multipurpose_out_pin_o;
   endproperty
   a_lock: assert property (p_lock) else $error("lock not shown");

   property p_chd;
      !chdiv_o.master |-> chdiv_o.seg_on == 3'h0 && chdiv_o.ratio == 8'h00;
   endproperty
   a_chd: assert property (p_chd) else $error("divider stage left on");

   property p_seed;
      s_wr(A_SEED_LO) ##0 ord != ORD_INT |=> seed_pulse_o ##1 !seed_pulse_o;
   endproperty
   a_seed: assert property (p_seed) else $error("seed write lost");

   // The difference history needs four clocks to drain after leaving fractional mode
   property p_int;
      (mash_order_o == ORD_INT && $stable(q.regs[A_NINT])) [*5]
         |-> n_div_o == {1'h0, q.regs[A_NINT][NINT_LSB +: NINT_W]};
   endproperty
   a_int: assert property (p_int) else $error("integer mode ratio wrong");
endmodule

// File: test/fsc_host_model.sv
/*
 Host model of the serial programming port: sends frames, captures readback
 bits from the pin and can toggle the link clock with chip select high.
 Assumes its caller waits for each task to return before starting another.
*/
module fsc_host_model
   import fsc_pkg::*;
(
   // Readback pin
   input wire logic pin_i,
   // Serial lines
   output logic sclk_o,
   output logic chip_select_n_o,
   output logic sdi_o,
   // Captured read data
   output logic [DATA_W-1:0] rd_data_o,
   output logic rd_tog_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sclk_o = 1'b0;
      chip_select_n_o = 1'b1;
      sdi_o = 1'b0;
      rd_data_o = '0;
      rd_tog_o = 1'b0;
   end

   // Link clock runs only inside the frame
   task automatic xfer(input fsc_frame_t f, input int nbits);
      logic [DATA_W-1:0] r;
      r = '0;
      #3;
      chip_select_n_o = 1'b0;
      for (int k = 0; k < nbits; k++) begin
         sdi_o = f[FRAME_W-1-k];
         #16;
         if (k >= 8) r[FRAME_W-1-k] = pin_i;
         sclk_o = 1'b1;
         #32;
         sclk_o = 1'b0;
         #16;
      end
      chip_select_n_o = 1'b1;
      sdi_o = ~sdi_o;
      if (f.rd) begin
         rd_data_o = r;
         rd_tog_o = ~rd_tog_o;
      end
      #64;
   endtask

   // Clock pulses while chip select is high
   task automatic stray();
      repeat (3) begin
         #32 sclk_o = 1'b1;
         #32 sclk_o = 1'b0;
      end
   endtask
endmodule

// File: test/fsc_top_tb_top.sv
/*
 Self-checking bench of the serial control block: register traffic through the
 host model, a pulse and readback scoreboard, divider, power and lock checks.
 Assumes fsc_pkg, fsc_top and fsc_host_model are compiled before it.
*/
module fsc_top_tb_top
   import fsc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i;
   logic arst_n_i;
   logic chip_enable_i;
   logic lock_i;
   logic sclk, csn, sdi, pin, pd, cal, seedp, osc2x, lden, msel, a_sel, b_sel, rd_tog;
   logic [NINT_W:0] n_div;
   logic [ORD_W-1:0] order;
   logic [2:0] pre;
   logic [DLY_W-1:0] dly;
   logic [3:0] dl;
   logic [LV_W-1:0] a_lv, b_lv;
   fsc_chdiv_t chdiv;
   logic [DATA_W-1:0] rd_data, d;
   logic last_tog = 1'b0;
   logic [17:0] exp_q[$];
   logic [20:0] sum;
   logic [ADDR_W-1:0] addrs [5] = '{A_NINT, A_DEN_HI, A_NUM_LO, A_NUM_HI, A_OUT};
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 32'h2248;

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   fsc_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .chip_select_n_i(csn), .sdi_i(sdi),
      .chip_enable_i(chip_enable_i), .lock_i(lock_i), .multipurpose_out_pin_o(pin), .power_down_o(pd),
      .freq_cal_start_o(cal), .seed_pulse_o(seedp), .n_div_o(n_div), .mash_order_o(order), .pre_ratio_o(pre),
      .detector_delay_select_o(dly), .osc_doubler_enable_o(osc2x), .lock_detect_enable_o(lden),
      .multipurpose_out_select_o(msel), .chdiv_o(chdiv), .out_a_sel_o(a_sel), .out_b_sel_o(b_sel),
      .out_a_level_o(a_lv), .out_b_level_o(b_lv));

   fsc_host_model i_host (.pin_i(pin), .sclk_o(sclk), .chip_select_n_o(csn), .sdi_o(sdi),
      .rd_data_o(rd_data), .rd_tog_o(rd_tog));

   // ------------------------------
   // Checking
   // ------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic take(input logic [17:0] got);
      if (exp_q.size() == 0) check(got, 32'h3ffff);
      else check(got, exp_q.pop_front());
   endtask

   task automatic end_sim();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Outputs are looked at on the falling edge, where they have settled
   always @(negedge clk_i) begin
      if (cal === 1'b1) take({2'h1, 16'h0000});
      if (seedp === 1'b1) take({2'h2, 16'h0000});
      if (rd_tog !== last_tog) begin
         last_tog <= rd_tog;
         take({2'h0, rd_data});
      end
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      i_host.xfer({1'b0, a, v}, 24);
      repeat (8) @(negedge clk_i);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      exp_q.push_back({2'h0, e});
      i_host.xfer({1'b1, a, 16'($random(seed))}, 24);
      repeat (8) @(negedge clk_i);
   endtask

   // ------------------------------
   // Stimulus
   // ------------------------------
   initial begin
      arst_n_i = 1'b0;
      chip_enable_i = 1'b1;
      lock_i = 1'b0;
      repeat (20) @(negedge clk_i);
      arst_n_i = 1'b1;
      repeat (8) @(negedge clk_i);
      check(pd, 1'b0);
      rd(A_CTRL, CTRL_DEF);
      rd(A_DEN_LO, DEN_LO_DEF);
      wr(A_CTRL, CTRL_DEF | 16'h0002);
      foreach (addrs[i]) begin
         d = 16'($random(seed));
         wr(addrs[i], d);
         i_host.xfer({1'b0, addrs[i], ~d}, 23);
         rd(addrs[i], d);
         i_host.stray();
         rd(addrs[i], d);
      end
      exp_q.push_back({2'h1, 16'h0000});
      wr(A_CTRL, CTRL_DEF | 16'h0008);
      wr(A_CTRL, CTRL_DEF | 16'h0002);
      rd(A_NUM_HI, 16'h0000);
      rd(A_CTRL, CTRL_DEF);
      for (int m = 0; m < 4; m++) begin
         wr(A_LOOP, 16'(m));
         check(pre, (m == 0) ? PRE_LO : PRE_HI);
         check(osc2x, m[1]);
      end
      wr(A_NINT, 16'h0050);
      wr(A_DEN_LO, 16'd1000);
      for (int o = 1; o <= 4; o++) begin
         dl = (o == 4) ? 4'h8 : ((o >= 2) ? 4'h2 : 4'h1);
         wr(A_LOOP, {7'h00, dl, 3'(o), 2'h0});
         check({order, dly}, {3'(o), dl});
         wr(A_SEED_HI, 16'h0000);
         exp_q.push_back({2'h2, 16'h0000});
         wr(A_SEED_LO, 16'h0007);
      end
      wr(A_LOOP, 16'h0020);
      wr(A_SEED_LO, 16'h0003);
      wr(A_NUM_LO, 16'h0003);
      check(n_div, 40);
      wr(A_DEN_HI, 16'h0001);
      wr(A_DEN_LO, 16'h0000);
      wr(A_NUM_LO, 16'h8000);
      wr(A_LOOP, 16'h0024);
      sum = '0;
      repeat (256) begin
         @(negedge clk_i);
         sum = sum + 21'(n_div);
      end
      check(sum, 21'd10368);
      // Master enable, all stage enables, both buffers, three stages in the path
      wr(A_CHDIV, 16'h7f49);
      check(chdiv, {1'b1, 3'h7, 2'h3, 8'hc0});
      wr(A_CHDIV, 16'h0600);
      check(chdiv, {1'b1, 3'h1, 2'h0, 8'h02});
      // Same setting with the master enable cleared
      wr(A_CHDIV, 16'h7d49);
      check(chdiv, 14'h0000);
      wr(A_OUT, 16'h2a55);
      check({a_sel, b_sel, a_lv, b_lv}, {2'h2, 6'h15, 6'h2a});
      chip_enable_i = 1'b0;
      repeat (6) @(negedge clk_i);
      check(pd, 1'b1);
      chip_enable_i = 1'b1;
      repeat (6) @(negedge clk_i);
      check(pd, 1'b0);
      wr(A_CTRL, CTRL_DEF | 16'h0001);
      check(pd, 1'b1);
      exp_q.push_back({2'h1, 16'h0000});
      wr(A_CTRL, CTRL_DEF | 16'h0008);
      check(pd, 1'b0);
      wr(A_CTRL, CTRL_DEF | 16'h2004);
      check({lden, msel}, 2'h3);
      repeat (8) begin
         lock_i = 1'($random(seed));
         repeat (4) @(negedge clk_i);
         check(pin, lock_i);
      end
      wr(A_CTRL, CTRL_DEF);
      rd(A_OUT, 16'h2a55);
      repeat (20) @(negedge clk_i);
      check(exp_q.size(), 0);
      end_sim();
   end
endmodule
